// ==== literal_swap_return_instr_exec.sv ====
// execution of option load, literal return, nibble exchange and literal xor
// assumes a core sequencer that offers one word at a time and holds it
// while busy_o is high; register file read is combinational
// Behaviour
// RULE_01: the fixed option load word copies the accumulator into option.
// RULE_02: the legacy option load stays decoded for old code.
// RULE_03: return_with_literal loads its 8-bit literal into the accumulator.
// RULE_04: return_with_literal pops the stack; pc takes stack_top_entry.
// RULE_05: return_with_literal takes two instruction cycles, one word.
// RULE_06: nibble_exchange reads file register at low 7 bits, swaps halves.
// RULE_07: destination bit 0 writes accumulator, 1 writes the file register.
// RULE_08: exclusive_or_literal xors accumulator with the word's low byte.
// RULE_09: xor result goes to accumulator; zero flag shows if result is zero.
// RULE_10: only exclusive_or_literal changes the zero flag.
// RULE_11: option load, swap and xor finish in one cycle, one word.
`timescale 1ns/100ps
module literal_swap_return_instr_exec (
  input  wire logic                              core_clk_i,      // core clock
  input  wire logic                              sys_rst_i,       // sync reset
  input  wire logic                              instr_valid_i,   // word offered
  input  wire logic [lsr_exec_pkg::INSTR_W-1:0]  instr_i,         // word
  output logic                                   busy_o,          // 2nd cycle
  output logic [lsr_exec_pkg::FADDR_W-1:0]       file_addr_o,     // file addr
  input  wire logic [lsr_exec_pkg::DATA_W-1:0]   file_rd_data_i,  // file data
  output logic                                   file_wr_en_o,    // file write
  output logic [lsr_exec_pkg::FADDR_W-1:0]       file_wr_addr_o,  // write addr
  output logic [lsr_exec_pkg::DATA_W-1:0]        file_wr_data_o,  // write data
  input  wire logic [lsr_exec_pkg::PC_W-1:0]     stack_top_entry_i, // ret addr
  output logic                                   stack_pop_o,     // pop pulse
  output logic                                   pc_load_o,       // pc load
  output logic [lsr_exec_pkg::PC_W-1:0]          pc_load_val_o,   // new pc
  output logic [lsr_exec_pkg::DATA_W-1:0]        acc_o,           // accum
  output logic [lsr_exec_pkg::DATA_W-1:0]        option_o,        // option reg
  output logic                                   zero_flag_o      // zero flag
);
  typedef enum logic {ST_EXEC, ST_RET_SECOND} state_e;

  lsr_decode_if dec_bus ();

  lsr_decoder u_dec (
    .instr_i (instr_i),
    .dec_o   (dec_bus)
  );

  state_e                              state_ff, nxt_state;
  logic [lsr_exec_pkg::DATA_W-1:0]     acc_ff, nxt_acc;
  logic [lsr_exec_pkg::DATA_W-1:0]     option_ff, nxt_option;
  logic                                zero_ff, nxt_zero;
  logic                                wr_en_ff, nxt_wr_en;
  logic [lsr_exec_pkg::FADDR_W-1:0]    wr_addr_ff, nxt_wr_addr;
  logic [lsr_exec_pkg::DATA_W-1:0]     wr_data_ff, nxt_wr_data;
  logic                                pop_ff, nxt_pop;
  logic                                pc_ld_ff, nxt_pc_ld;
  logic [lsr_exec_pkg::PC_W-1:0]       pc_val_ff, nxt_pc_val;
  logic [lsr_exec_pkg::DATA_W-1:0]     swapped;
  logic [lsr_exec_pkg::DATA_W-1:0]     xor_res;
  logic                                take;
  logic                                do_opt;
  logic                                do_ret;
  logic                                do_swap_acc;
  logic                                do_swap_file;
  logic                                do_xor;

  // new word is only taken in the first cycle of an instruction
  assign take        = instr_valid_i && (state_ff == ST_EXEC);
  assign file_addr_o = dec_bus.faddr;                       // see RULE_06
  assign swapped     = {file_rd_data_i[lsr_exec_pkg::NIB_W-1:0],
                        file_rd_data_i[lsr_exec_pkg::DATA_W-1:
                                       lsr_exec_pkg::NIB_W]}; // see RULE_06
  assign xor_res     = acc_ff ^ dec_bus.literal;            // see RULE_08

  // one qualified strobe per operation keeps the groups below independent
  always_comb begin
    do_opt       = 1'h0;
    do_ret       = 1'h0;
    do_swap_acc  = 1'h0;
    do_swap_file = 1'h0;
    do_xor       = 1'h0;
    if (take) begin
      case (dec_bus.op)
        lsr_exec_pkg::OP_OPT_LOAD: begin
          do_opt = 1'h1;                                    // see RULE_01
        end
        lsr_exec_pkg::OP_RET_LIT: begin
          do_ret = 1'h1;                                    // see RULE_03
        end
        lsr_exec_pkg::OP_SWAP: begin
          do_swap_file = dec_bus.dest_file;                 // see RULE_07
          do_swap_acc  = !dec_bus.dest_file;                // see RULE_07
        end
        lsr_exec_pkg::OP_XOR_LIT: begin
          do_xor = 1'h1;                                    // see RULE_08
        end
        default: begin
          do_opt = 1'h0;
        end
      endcase
    end
  end

  // only the literal return owns a second cycle
  always_comb begin
    nxt_state = ST_EXEC;                                    // see RULE_11
    case (state_ff)
      ST_EXEC: begin
        if (do_ret) begin
          nxt_state = ST_RET_SECOND;                        // see RULE_05
        end
      end
      ST_RET_SECOND: begin
        nxt_state = ST_EXEC;
      end
      default: begin
        nxt_state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= ST_EXEC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // flags hold unless the literal xor runs
  always_comb begin
    nxt_acc  = acc_ff;
    nxt_zero = zero_ff;                                     // see RULE_10
    if (do_ret) begin
      nxt_acc = dec_bus.literal;                            // see RULE_03
    end else if (do_swap_acc) begin
      nxt_acc = swapped;                                    // see RULE_07
    end else if (do_xor) begin
      nxt_acc  = xor_res;                                   // see RULE_09
      nxt_zero = (xor_res == lsr_exec_pkg::ZERO_BYTE);      // see RULE_09
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      acc_ff  <= lsr_exec_pkg::ACC_RST;
      zero_ff <= 1'h0;
    end else begin
      acc_ff  <= nxt_acc;
      zero_ff <= nxt_zero;
    end
  end

  // legacy load kept for old code; nothing else here writes option
  always_comb begin
    nxt_option = option_ff;
    if (do_opt) begin
      nxt_option = acc_ff;                                  // see RULE_01
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      option_ff <= lsr_exec_pkg::OPTION_RST;
    end else begin
      option_ff <= nxt_option;
    end
  end

  // enable pulses one cycle; address and data stand until the next write
  always_comb begin
    nxt_wr_en   = 1'h0;
    nxt_wr_addr = wr_addr_ff;
    nxt_wr_data = wr_data_ff;
    if (do_swap_file) begin
      nxt_wr_en   = 1'h1;                                   // see RULE_07
      nxt_wr_addr = dec_bus.faddr;                          // see RULE_06
      nxt_wr_data = swapped;                                // see RULE_06
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      wr_en_ff   <= 1'h0;
      wr_addr_ff <= '0;
      wr_data_ff <= lsr_exec_pkg::ZERO_BYTE;
    end else begin
      wr_en_ff   <= nxt_wr_en;
      wr_addr_ff <= nxt_wr_addr;
      wr_data_ff <= nxt_wr_data;
    end
  end

  // pop and pc load share one edge so the pc never takes a stale top
  always_comb begin
    nxt_pop    = 1'h0;
    nxt_pc_ld  = 1'h0;
    nxt_pc_val = pc_val_ff;
    if (do_ret) begin
      nxt_pop    = 1'h1;                                    // see RULE_04
      nxt_pc_ld  = 1'h1;                                    // see RULE_04
      nxt_pc_val = stack_top_entry_i;                       // see RULE_04
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pop_ff    <= 1'h0;
      pc_ld_ff  <= 1'h0;
      pc_val_ff <= '0;
    end else begin
      pop_ff    <= nxt_pop;
      pc_ld_ff  <= nxt_pc_ld;
      pc_val_ff <= nxt_pc_val;
    end
  end

  // second cycle of the literal return is a flush slot, see RULE_05
  assign busy_o         = (state_ff == ST_RET_SECOND);
  assign file_wr_en_o   = wr_en_ff;
  assign file_wr_addr_o = wr_addr_ff;
  assign file_wr_data_o = wr_data_ff;
  assign stack_pop_o    = pop_ff;
  assign pc_load_o      = pc_ld_ff;
  assign pc_load_val_o  = pc_val_ff;
  assign acc_o          = acc_ff;
  assign option_o       = option_ff;
  assign zero_flag_o    = zero_ff;
endmodule

// ==== lsr_exec_pkg.sv ====
// constants for the literal, swap and return execution block
// assumes a 14-bit instruction word and an 8-bit data path
package lsr_exec_pkg;
  localparam int unsigned   INSTR_W      = 14;
  localparam int unsigned   DATA_W       = 8;
  localparam int unsigned   FADDR_W      = 7;
  localparam int unsigned   PC_W         = 13;
  localparam int unsigned   NIB_W        = 4;
  localparam int unsigned   DEST_BIT     = 7;
  localparam int unsigned   OP6_HI       = 13;
  localparam int unsigned   OP6_LO       = 8;
  localparam int unsigned   OP4_LO       = 10;
  // fixed word of the legacy option load
  localparam logic [13:0]   OPT_LOAD_WORD = 14'h0062;
  // upper opcode fields
  localparam logic [3:0]    RET_LIT_OP4  = 4'hD;
  localparam logic [5:0]    XOR_LIT_OP6  = 6'h3A;
  localparam logic [5:0]    SWAP_OP6     = 6'h0E;
  localparam logic [7:0]    OPTION_RST   = 8'hFF;
  localparam logic [7:0]    ACC_RST      = 8'h00;
  localparam logic [7:0]    ZERO_BYTE    = 8'h00;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_OPT_LOAD,
    OP_RET_LIT,
    OP_SWAP,
    OP_XOR_LIT
  } op_e;
endpackage

// ==== lsr_decode_if.sv ====
// carries one decoded instruction from the decoder to the executor
// assumes both ends sit on the same core clock
`timescale 1ns/100ps
interface lsr_decode_if;
  lsr_exec_pkg::op_e                          op;
  logic [lsr_exec_pkg::DATA_W-1:0]            literal;
  logic [lsr_exec_pkg::FADDR_W-1:0]           faddr;
  logic                                       dest_file;
  modport dec (output op, output literal, output faddr, output dest_file);
  modport exe (input op, input literal, input faddr, input dest_file);
endinterface

// ==== lsr_decoder.sv ====
// pure decoder of the four handled instruction words
// assumes the word is stable while it is examined
`timescale 1ns/100ps
module lsr_decoder (
  input  wire logic [lsr_exec_pkg::INSTR_W-1:0] instr_i, // instruction word
  lsr_decode_if.dec                             dec_o    // decoded fields
);
  always_comb begin
    dec_o.literal   = instr_i[lsr_exec_pkg::DATA_W-1:0];
    dec_o.faddr     = instr_i[lsr_exec_pkg::FADDR_W-1:0];
    dec_o.dest_file = instr_i[lsr_exec_pkg::DEST_BIT];
    // still decoded for old code even though software should avoid it
    if (instr_i == lsr_exec_pkg::OPT_LOAD_WORD) begin // see RULE_02
      dec_o.op = lsr_exec_pkg::OP_OPT_LOAD;            // see RULE_01
    end else if (instr_i[lsr_exec_pkg::OP6_HI:lsr_exec_pkg::OP4_LO]
                 == lsr_exec_pkg::RET_LIT_OP4) begin
      dec_o.op = lsr_exec_pkg::OP_RET_LIT;             // see RULE_03
    end else if (instr_i[lsr_exec_pkg::OP6_HI:lsr_exec_pkg::OP6_LO]
                 == lsr_exec_pkg::XOR_LIT_OP6) begin
      dec_o.op = lsr_exec_pkg::OP_XOR_LIT;             // see RULE_08
    end else if (instr_i[lsr_exec_pkg::OP6_HI:lsr_exec_pkg::OP6_LO]
                 == lsr_exec_pkg::SWAP_OP6) begin
      dec_o.op = lsr_exec_pkg::OP_SWAP;                // see RULE_06
    end else begin
      dec_o.op = lsr_exec_pkg::OP_NONE;
    end
  end
endmodule

// ==== literal_swap_return_instr_exec_properties.sv ====
// assertions on the literal, swap and return execution block
// assumes a bind to the block's top module with matching port names
`timescale 1ns/100ps
module lsr_exec_props (
  input wire logic        core_clk_i,        // clock
  input wire logic        sys_rst_i,         // reset
  input wire logic        instr_valid_i,     // offer
  input wire logic [13:0] instr_i,           // word
  input wire logic        busy_o,            // busy
  input wire logic [7:0]  file_rd_data_i,    // file data
  input wire logic        file_wr_en_o,      // file write
  input wire logic [6:0]  file_wr_addr_o,    // write addr
  input wire logic [7:0]  file_wr_data_o,    // write data
  input wire logic [12:0] stack_top_entry_i, // return addr
  input wire logic        stack_pop_o,       // pop
  input wire logic        pc_load_o,         // pc load
  input wire logic [12:0] pc_load_val_o,     // new pc
  input wire logic [7:0]  acc_o,             // accumulator
  input wire logic [7:0]  option_o,          // option
  input wire logic        zero_flag_o        // zero
);
  logic       take, ret, xr, sw;
  logic [7:0] swp;
  assign take = instr_valid_i && !busy_o;
  assign ret  = take && instr_i[13:10] == 4'hD;
  assign xr   = take && instr_i[13:8] == 6'h3A;
  assign sw   = take && instr_i[13:8] == 6'h0E;
  assign swp  = {file_rd_data_i[3:0], file_rd_data_i[7:4]};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_opt_copy: assert property (take && instr_i == 14'h0062
    |=> option_o == $past(acc_o)) else $error("option load wrong");
  a_ret_acc: assert property (ret
    |=> acc_o == $past(instr_i[7:0])
    && pc_load_val_o == $past(stack_top_entry_i)) else $error("ret value");
  a_ret_pop: assert property (ret |=> stack_pop_o && pc_load_o
    ##1 !stack_pop_o && !pc_load_o) else $error("ret pop wrong");
  a_ret_busy: assert property (ret |=> busy_o ##1 !busy_o)
    else $error("ret length wrong");
  a_swap_acc: assert property (sw && !instr_i[7]
    |=> acc_o == $past(swp) && !file_wr_en_o) else $error("swap to acc");
  a_swap_file: assert property (sw && instr_i[7]
    |=> file_wr_en_o && file_wr_data_o == $past(swp) && $stable(acc_o)
    && file_wr_addr_o == $past(instr_i[6:0])) else $error("swap to file");
  a_xor_acc: assert property (xr
    |=> acc_o == $past(acc_o ^ instr_i[7:0])
    && zero_flag_o == (acc_o == 8'h00)) else $error("xor result wrong");
  a_zero_keep: assert property (!xr |=> $stable(zero_flag_o))
    else $error("zero flag moved");
  a_one_cycle: assert property (take && !ret |=> !busy_o)
    else $error("single cycle op busy");
  c_ret_stall: cover property (ret ##1 instr_valid_i);
  c_swap_file: cover property (sw && instr_i[7]);
  c_xor_zero: cover property (xr ##1 zero_flag_o);
endmodule

// ==== test_literal_swap_return_instr_exec.sv ====
// self-checking bench for the literal, swap and return execution block
// assumes package, interface, design and checker are compiled first
`timescale 1ns/100ps
module test_literal_swap_return_instr_exec;
  logic        core_clk_i, sys_rst_i, instr_valid_i, busy_o, file_wr_en_o;
  logic        stack_pop_o, pc_load_o, zero_flag_o;
  logic [13:0] instr_i;
  logic [12:0] stack_top_entry_i, pc_load_val_o;
  logic [7:0]  file_rd_data_i, file_wr_data_o, acc_o, option_o;
  logic [6:0]  file_addr_o, file_wr_addr_o;
  int          n_mismatch, tests_run;
  literal_swap_return_instr_exec dut_u (
    .core_clk_i        (core_clk_i),
    .sys_rst_i         (sys_rst_i),
    .instr_valid_i     (instr_valid_i),
    .instr_i           (instr_i),
    .busy_o            (busy_o),
    .file_addr_o       (file_addr_o),
    .file_rd_data_i    (file_rd_data_i),
    .file_wr_en_o      (file_wr_en_o),
    .file_wr_addr_o    (file_wr_addr_o),
    .file_wr_data_o    (file_wr_data_o),
    .stack_top_entry_i (stack_top_entry_i),
    .stack_pop_o       (stack_pop_o),
    .pc_load_o         (pc_load_o),
    .pc_load_val_o     (pc_load_val_o),
    .acc_o             (acc_o),
    .option_o          (option_o),
    .zero_flag_o       (zero_flag_o)
  );
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
    tests_run++;
    if (got !== ex) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // last=0 keeps the word offered so the next call lands back to back
  task automatic offer(logic [13:0] w, logic [7:0] rd, bit last);
    @(posedge core_clk_i);
    instr_valid_i  <= 1'b1;
    instr_i        <= w;
    file_rd_data_i <= rd;
    if (last) begin
      @(posedge core_clk_i);
      instr_valid_i <= 1'b0;
      #1;
    end
  endtask
  task automatic give_verdict;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_option;
    chk("option reset", 8'hFF, option_o);
    offer(14'h3A5A, 8'h00, 1);
    offer(14'h0062, 8'h00, 1);
    chk("option", 8'h5A, option_o);
  endtask
  task automatic t_xor;
    offer(14'h3A0F, 8'h00, 0);
    offer(14'h3AF0, 8'h00, 1);
    chk("acc xor", 8'hA5, acc_o);
    offer(14'h3AA5, 8'h00, 1);
    chk("zero", 1'h1, zero_flag_o);
  endtask
  task automatic t_swap;
    offer(14'h0E7F, 8'hA5, 0);
    #1 chk("file addr", 7'h7F, file_addr_o);
    @(posedge core_clk_i);
    instr_valid_i <= 1'b0;
    #1 chk("acc swap", 8'h5A, acc_o);
    offer(14'h0E83, 8'h3C, 1);
    chk("wr data", {1'b1, 7'h03, 8'hC3},
        {file_wr_en_o, file_wr_addr_o, file_wr_data_o});
    chk("acc kept", 8'h5A, acc_o);
    chk("zero kept", 1'h1, zero_flag_o);
  endtask
  // a word offered in the busy slot must be ignored
  task automatic t_ret;
    offer(14'h36FF, 8'h00, 0);
    @(posedge core_clk_i);
    instr_i <= 14'h3A55;
    #1 chk("acc ret", 8'hFF, acc_o);
    chk("pc", 13'h1ABC, pc_load_val_o);
    chk("ret pulses", 2'h3, {stack_pop_o, pc_load_o});
    chk("ret busy", 1'h1, busy_o);
    @(posedge core_clk_i);
    instr_valid_i <= 1'h0;
    #1 chk("acc in busy", 8'hFF, acc_o);
    chk("ret end", 3'h0, {stack_pop_o, pc_load_o, busy_o});
    chk("ret zero", 1'h1, zero_flag_o);
  endtask
  // one bit off the option load word must do nothing
  task automatic t_none;
    offer(14'h0063, 8'hFF, 1);
    chk("near opt", 8'h5A, option_o);
    chk("near acc", 8'hFF, acc_o);
    chk("near zero", 1'h1, zero_flag_o);
  endtask
  initial begin
    n_mismatch = 0;
    tests_run = 0;
    sys_rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '0;
    file_rd_data_i = '0;
    stack_top_entry_i = 13'h1ABC;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    t_option();
    t_xor();
    t_swap();
    t_ret();
    t_none();
    give_verdict();
  end
  initial begin
    #20000;
    n_mismatch++;
    give_verdict();
  end
endmodule
bind literal_swap_return_instr_exec lsr_exec_props props_u (
  .core_clk_i        (core_clk_i),
  .sys_rst_i         (sys_rst_i),
  .instr_valid_i     (instr_valid_i),
  .instr_i           (instr_i),
  .busy_o            (busy_o),
  .file_rd_data_i    (file_rd_data_i),
  .file_wr_en_o      (file_wr_en_o),
  .file_wr_addr_o    (file_wr_addr_o),
  .file_wr_data_o    (file_wr_data_o),
  .stack_top_entry_i (stack_top_entry_i),
  .stack_pop_o       (stack_pop_o),
  .pc_load_o         (pc_load_o),
  .pc_load_val_o     (pc_load_val_o),
  .acc_o             (acc_o),
  .option_o          (option_o),
  .zero_flag_o       (zero_flag_o)
);
